// ---- src/spa_array.sv ----
/*
  Field-configurable sum-of-products array with eight output macrocells and an
  APB-reached configuration store. Assumes all pins are synchronous to pclk and
  that the device clock pin is sampled, its rising edge acting as an enable.
*/
`timescale 1ns/10ps
`include "spa_cfg.svh"

module spa_array (
  input  wire logic                  pclk,
  input  wire logic                  presetn,
  input  wire spa_pkg::spa_apb_req_t apb_req,
  output      spa_pkg::spa_apb_rsp_t apb_rsp,
  input  wire logic [7:0]            din,
  input  wire logic                  dev_clk,
  input  wire logic                  oe_n,
  input  wire logic [7:0]            f_in,
  output      logic [7:0]            f_out,
  output      logic [7:0]            f_oe
);
  import spa_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // Configuration store

  logic [63:0]              and_q [`SPA_AND_ROWS];
  logic [63:0]              sig_q;
  logic [`SPA_ACW_BITS-1:0] acw_q;
  logic                     sec_q;
  logic [5:0]               row_q;
  logic [31:0]              wd0_q;
  logic [31:0]              wd1_q;
  logic [31:0]              wd2_q;
  logic [31:0]              prdata_q;
  logic [`SPA_ACW_BITS-1:0] rb_row;

  logic [7:0]               macro_q;
  logic [7:0]               f_out_q;
  logic [7:0]               f_oe_q;
  logic                     clk_pin_q;
  logic [`SPA_RST_CNT_W-1:0] rst_cnt_q;

  logic [63:0]              pt;
  logic [31:0]              lines;
  logic [15:0]              in_vec;
  logic [7:0]               cell_sum;
  logic [7:0]               cell_pval;
  logic [7:0]               cell_oe;
  logic [7:0]               cell_out;
  logic [7:0]               cell_is_reg;
  spa_mode_t                mode;
  logic                     dev_edge;

  wire logic [63:0] ptd = acw_q[`SPA_ACW_PTD_LSB +: 64];
  wire logic [7:0]  pol = acw_q[`SPA_ACW_POL_LSB +: 8];
  wire logic [7:0]  ac1 = acw_q[`SPA_ACW_AC1_LSB +: 8];

  ////////////////////////////////////////////////////////////////////////////
  // Helpers

  function automatic spa_mode_t spa_mode_of(input logic syn, input logic ac0);
    if (!syn) begin
      return SPA_MODE_REG;
    end
    return ac0 ? SPA_MODE_CPLX : SPA_MODE_SIMPLE;
  endfunction

  function automatic logic spa_addr_ok(input logic [7:0] a);
    return (a == `SPA_OFF_ROW) || (a == `SPA_OFF_WD0) || (a == `SPA_OFF_WD1) ||
           (a == `SPA_OFF_WD2) || (a == `SPA_OFF_CMD) || (a == `SPA_OFF_RD0) ||
           (a == `SPA_OFF_RD1) || (a == `SPA_OFF_RD2) || (a == `SPA_OFF_STATUS);
  endfunction

  assign mode = spa_mode_of(acw_q[`SPA_ACW_SYN_BIT], acw_q[`SPA_ACW_AC0_BIT]);  // R25 R7

  ////////////////////////////////////////////////////////////////////////////
  // APB slave, zero wait states

  wire logic setup_rd = apb_req.psel && !apb_req.penable && !apb_req.pwrite;
  wire logic acc      = apb_req.psel && apb_req.penable;
  wire logic wr       = acc && apb_req.pwrite && spa_addr_ok(apb_req.paddr);
  wire logic prog     = wr && (apb_req.paddr == `SPA_OFF_CMD) &&
                        apb_req.pwdata[`SPA_CMD_PROG_BIT];

  assign apb_rsp.prdata  = prdata_q;
  assign apb_rsp.pready  = acc;
  assign apb_rsp.pslverr = acc && !spa_addr_ok(apb_req.paddr);

  always_comb begin
    rb_row = '0;
    if (row_q < 6'(`SPA_AND_ROWS)) begin
      if (!sec_q) begin  // R20
        rb_row = {18'h0, and_q[row_q[4:0]]};
      end
    end else if (row_q == `SPA_ROW_SIG) begin
      rb_row = {18'h0, sig_q};  // R17
    end else if (row_q == `SPA_ROW_ACW) begin
      rb_row = acw_q;
    end else if (row_q == `SPA_ROW_SEC) begin
      rb_row = {81'h0, sec_q};
    end
  end

  // Read data is caught in the setup cycle so that the access phase can finish at once
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_q <= 32'h0;
    end else if (setup_rd) begin
      unique case (apb_req.paddr)
        `SPA_OFF_ROW:    prdata_q <= {26'h0, row_q};
        `SPA_OFF_WD0:    prdata_q <= wd0_q;
        `SPA_OFF_WD1:    prdata_q <= wd1_q;
        `SPA_OFF_WD2:    prdata_q <= wd2_q;
        `SPA_OFF_RD0:    prdata_q <= rb_row[31:0];
        `SPA_OFF_RD1:    prdata_q <= rb_row[63:32];
        `SPA_OFF_RD2:    prdata_q <= {14'h0, rb_row[81:64]};
        `SPA_OFF_STATUS: prdata_q <= {12'h0, rst_cnt_q == '0, 2'(mode), sec_q,
                                      f_oe_q, f_out_q};
        default:         prdata_q <= 32'h0;
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      row_q <= 6'h0;
      wd0_q <= 32'h0;
      wd1_q <= 32'h0;
      wd2_q <= 32'h0;
    end else if (wr) begin
      if (apb_req.paddr == `SPA_OFF_ROW) begin
        row_q <= apb_req.pwdata[5:0];
      end
      if (apb_req.paddr == `SPA_OFF_WD0) begin
        wd0_q <= apb_req.pwdata;
      end
      if (apb_req.paddr == `SPA_OFF_WD1) begin
        wd1_q <= apb_req.pwdata;
      end
      if (apb_req.paddr == `SPA_OFF_WD2) begin
        wd2_q <= apb_req.pwdata;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Programming cycles; reserved and unused rows are simply ignored

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int r = 0; r < `SPA_AND_ROWS; r++) begin
        and_q[r] <= `SPA_ERASED_ROW;
      end
      sig_q <= `SPA_ERASED_ROW;
      acw_q <= `SPA_ERASED_ACW;
      sec_q <= `SPA_ERASED_SEC;
    end else if (prog) begin
      if (row_q == `SPA_ROW_ERASE) begin
        for (int r = 0; r < `SPA_AND_ROWS; r++) begin
          and_q[r] <= `SPA_ERASED_ROW;  // R21
        end
        sig_q <= `SPA_ERASED_ROW;  // R24
        acw_q <= `SPA_ERASED_ACW;  // R24
        sec_q <= `SPA_ERASED_SEC;  // R24
      end else if (row_q < 6'(`SPA_AND_ROWS)) begin
        and_q[row_q[4:0]] <= {wd1_q, wd0_q};  // R16
      end else if (row_q == `SPA_ROW_SIG) begin
        sig_q <= {wd1_q, wd0_q};  // R17
      end else if (row_q == `SPA_ROW_ACW) begin
        acw_q <= {wd2_q[17:0], wd1_q, wd0_q};  // R19
      end else if (row_q == `SPA_ROW_SEC) begin
        sec_q <= wd0_q[0];  // R20
      end
    end
  end

  a_prog_row_zero: assert property (  // R16
    @(posedge pclk) disable iff (!presetn)
    (prog && row_q == 6'd0) |=> (and_q[0] == {$past(wd1_q), $past(wd0_q)}))
    else $error("Row zero did not take the staged pattern");

  a_acw_load: assert property (  // R19
    @(posedge pclk) disable iff (!presetn)
    (prog && row_q == `SPA_ROW_ACW) |=> (acw_q[63:0] == {$past(wd1_q), $past(wd0_q)}))
    else $error("Architecture word did not take the staged value");

  ////////////////////////////////////////////////////////////////////////////
  // AND plane

  always_comb begin
    in_vec[7:0] = din;
    for (int c = 0; c < 8; c++) begin
      if (mode == SPA_MODE_REG) begin
        in_vec[8+c] = ac1[c] ? f_in[c] : macro_q[c];  // R8
      end else if (c == 0) begin
        in_vec[8+c] = dev_clk;  // R13 R10
      end else if (c == 7) begin
        in_vec[8+c] = oe_n;  // R13 R10
      end else begin
        in_vec[8+c] = f_in[c];
      end
    end
  end

  a_reg_feedback: assert property (  // R8
    @(posedge pclk) disable iff (!presetn)
    (mode == SPA_MODE_REG && !ac1[3]) |-> (lines[22] == macro_q[3]))
    else $error("Registered cell does not feed its register back");

  // Even line is the true input, odd line its complement
  always_comb begin
    for (int k = 0; k < 16; k++) begin
      lines[2*k]   = in_vec[k];  // R1
      lines[2*k+1] = !in_vec[k];  // R1
    end
  end

  // Erased cells connect both polarities, so an unprogrammed term is low
  always_comb begin
    for (int t = 0; t < `SPA_TERMS; t++) begin
      pt[t] = 1'b1;
      for (int r = 0; r < `SPA_AND_ROWS; r++) begin
        if (and_q[r][t] && !lines[r]) begin
          pt[t] = 1'b0;  // R1
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Output macrocells

  always_comb begin
    logic [7:0] grp;
    grp = 8'h0;
    cell_sum = 8'h0;
    cell_oe = 8'h0;
    for (int c = 0; c < 8; c++) begin
      grp = pt[c*8 +: 8] & ptd[c*8 +: 8];  // R2
      cell_is_reg[c] = 1'b0;
      unique case (mode)
        SPA_MODE_REG: begin
          if (!ac1[c]) begin
            cell_is_reg[c] = 1'b1;
            cell_sum[c] = |grp;  // R9
            cell_oe[c] = !oe_n;  // R6
          end else begin
            cell_sum[c] = |grp[7:1];  // R9 R3
            cell_oe[c] = pt[c*8];  // R3
          end
        end
        SPA_MODE_CPLX: begin
          cell_sum[c] = |grp[7:1];  // R11 R12
          cell_oe[c] = pt[c*8];  // R11 R12
        end
        SPA_MODE_SIMPLE: begin
          cell_sum[c] = |grp;  // R14
          cell_oe[c] = !ac1[c];  // R14
        end
      endcase
      cell_pval[c] = pol[c] ? cell_sum[c] : !cell_sum[c];  // R5 R22
      cell_out[c] = cell_is_reg[c] ? !macro_q[c] : cell_pval[c];
    end
  end

  a_pol_active_low: assert property (  // R5 R22
    @(posedge pclk) disable iff (!presetn)
    (mode == SPA_MODE_SIMPLE && !ac1[0] && !pol[0] && (pt[7:0] & ptd[7:0]) == 8'h0)
      |=> f_out[0])
    else $error("Active-low output not high with an empty sum");

  a_cplx_seven_terms: assert property (  // R11
    @(posedge pclk) disable iff (!presetn)
    (mode == SPA_MODE_CPLX && pol[1] && (pt[15:9] & ptd[15:9]) == 7'h0) |=> !f_out[1])
    else $error("Enable term leaked into the data sum");

  a_reg_oe_term: assert property (  // R9 R3
    @(posedge pclk) disable iff (!presetn)
    (mode == SPA_MODE_REG && ac1[0]) |=> (f_oe[0] == $past(pt[0])))
    else $error("Combinational cell enable does not follow its term");

  // Registers hold the inverse, so a cleared register drives the pin high
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      clk_pin_q <= 1'b0;
    end else begin
      clk_pin_q <= dev_clk;
    end
  end

  assign dev_edge = dev_clk && !clk_pin_q;

  // Device clock edges are ignored until the reset time has run out
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rst_cnt_q <= `SPA_RST_CNT_W'(`SPA_TRESET_CYC);  // R23
    end else if (rst_cnt_q != '0) begin
      rst_cnt_q <= rst_cnt_q - 1'b1;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      macro_q <= 8'h0;  // R23
    end else if (dev_edge && mode == SPA_MODE_REG && rst_cnt_q == '0) begin
      macro_q <= ~cell_pval;  // R15
    end
  end

  a_clk_reg_only: assert property (  // R15
    @(posedge pclk) disable iff (!presetn)
    (mode != SPA_MODE_REG) |=> $stable(macro_q))
    else $error("Macrocell register clocked outside registered mode");

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      f_out_q <= 8'h0;
      f_oe_q  <= 8'h0;
    end else begin
      f_out_q <= cell_out;
      f_oe_q  <= cell_oe;  // R4
    end
  end

  assign f_out = f_out_q;
  assign f_oe  = f_oe_q;

  ////////////////////////////////////////////////////////////////////////////
  // Checks

  a_reg_shared_oe: assert property (  // R6
    @(posedge pclk) disable iff (!presetn)
    (mode == SPA_MODE_REG && !ac1[0] && oe_n) |=> !f_oe[0])
    else $error("Registered cell driven while common enable is off");

  a_float_on_low: assert property (  // R4
    @(posedge pclk) disable iff (!presetn)
    (mode == SPA_MODE_CPLX && !pt[8]) |=> !f_oe[1])
    else $error("Driver enabled while its enable term is low");

  a_simple_always_on: assert property (  // R14
    @(posedge pclk) disable iff (!presetn)
    (mode == SPA_MODE_SIMPLE && !ac1[3]) |=> f_oe[3])
    else $error("Simple-mode output not permanently enabled");

  a_reset_hold_low: assert property (  // R23
    @(posedge pclk) disable iff (!presetn)
    (rst_cnt_q != '0) |-> (macro_q == 8'h0))
    else $error("Macrocell register left low state during reset time");

  a_erase_all: assert property (  // R24
    @(posedge pclk) disable iff (!presetn)
    (prog && row_q == `SPA_ROW_ERASE) |=>
      (!sec_q && acw_q == `SPA_ERASED_ACW && sig_q == `SPA_ERASED_ROW))
    else $error("Bulk erase left configuration programmed");

  a_secure_blocks: assert property (  // R20
    @(posedge pclk) disable iff (!presetn)
    (setup_rd && apb_req.paddr == `SPA_OFF_RD0 && sec_q && row_q < 6'd32)
      |=> (apb_rsp.prdata == 32'h0))
    else $error("Array read back while secured");

  a_sig_readable: assert property (  // R17
    @(posedge pclk) disable iff (!presetn)
    (setup_rd && apb_req.paddr == `SPA_OFF_RD1 && row_q == `SPA_ROW_SIG)
      |=> (apb_rsp.prdata == $past(sig_q[63:32])))
    else $error("Signature not returned on read");

  a_outer_inputs: assert property (  // R13
    @(posedge pclk) disable iff (!presetn)
    (mode != SPA_MODE_REG) |-> (lines[16] == dev_clk && lines[30] == oe_n))
    else $error("Clock or enable pin not routed into the array");

  a_reg_capture: assert property (  // R15
    @(posedge pclk) disable iff (!presetn)
    (dev_edge && mode == SPA_MODE_REG && rst_cnt_q == '0)
      |=> (macro_q[2] == !$past(cell_pval[2])))
    else $error("Macrocell register missed the clock edge");

endmodule

// ---- src/spa_cfg.svh ----
/*
  Constants for the sum-of-products array: register offsets, configuration row
  numbers, field positions within the architecture word, erased values and timing.
  Assumes a 40 MHz pclk and a 32-bit APB bus with byte addresses.

  // How it works
  // R1: Sixteen inputs, true and complemented, feed a 2048-cell AND plane giving 64 terms.
  // R2: Terms form eight groups of eight, one group per output macrocell.
  // R3: One term per group may enable a combinational output; the rest are ORed.
  // R4: An output driver floats whenever its enable is low.
  // R5: Each output has its own polarity bit, active high or low, in every mode.
  // R6: Registered outputs share the common enable pin; combinational ones use terms.
  // R7: Three modes, registered, complex and simple; all cells share one mode.
  // R8: Registered mode: each cell is registered output or combinational in/out.
  // R9: Registered cell gets eight data terms; combinational one seven plus enable term.
  // R10: Complex mode: outermost cells have no input path, six in/out at most.
  // R11: Complex mode: seven data terms, eighth term is the cell's own enable.
  // R12: Complex mode: outermost cells are fixed term-enabled combinational outputs.
  // R13: Complex and simple modes route clock and enable pins into the array.
  // R14: Simple mode: cell is dedicated input or always-on output with eight terms.
  // R15: Macrocell registers sample on the rising edge of the device clock.
  // R16: Rows 0 to 31 hold the AND-plane pattern, 64 bits each.
  // R17: Row 32 holds a 64-bit signature, readable regardless of security.
  // R18: Software must not use rows 33 to 59; they are reserved.
  // R19: Row 60 holds the 82-bit architecture and polarity control word.
  // R20: Row 61 holds the security bit; once set, array read-back is blocked.
  // R21: Programming row 63 bulk-erases all configuration.
  // R22: Eight polarity bits each control one output pin independently.
  // R23: At reset all macrocell registers clear low within the reset time.
  // R24: Bulk erase also clears architecture word, signature and security bit.
  // R25: Mode select: sync bit 0 registered; else arch mode bit 1 complex, 0 simple.
*/
`ifndef SPA_CFG_SVH
`define SPA_CFG_SVH

// APB register byte offsets
`define SPA_OFF_ROW      8'h00
`define SPA_OFF_WD0      8'h04
`define SPA_OFF_WD1      8'h08
`define SPA_OFF_WD2      8'h0c
`define SPA_OFF_CMD      8'h10
`define SPA_OFF_RD0      8'h14
`define SPA_OFF_RD1      8'h18
`define SPA_OFF_RD2      8'h1c
`define SPA_OFF_STATUS   8'h20
`define SPA_CMD_PROG_BIT 0

// Configuration rows
`define SPA_AND_ROWS     32
`define SPA_TERMS        64
`define SPA_ROW_SIG      6'd32
`define SPA_ROW_RSV_LO   6'd33
`define SPA_ROW_RSV_HI   6'd59
`define SPA_ROW_ACW      6'd60
`define SPA_ROW_SEC      6'd61
`define SPA_ROW_ERASE    6'd63

// Architecture word layout
`define SPA_ACW_BITS     82
`define SPA_ACW_PTD_LSB  0
`define SPA_ACW_POL_LSB  64
`define SPA_ACW_AC1_LSB  72
`define SPA_ACW_AC0_BIT  80
`define SPA_ACW_SYN_BIT  81

// Erased (unprogrammed) values
`define SPA_ERASED_ROW   64'hffff_ffff_ffff_ffff
`define SPA_ERASED_ACW   {`SPA_ACW_BITS{1'b1}}
`define SPA_ERASED_SEC   1'b0

// Timing
`define SPA_PCLK_NS      25
`define SPA_TRESET_NS    10000
`define SPA_TRESET_CYC   (`SPA_TRESET_NS / `SPA_PCLK_NS)
`define SPA_RST_CNT_W    9

`endif

// ---- src/spa_pkg.sv ----
/*
  Types shared by the sum-of-products array: operating modes and the APB carriers.
  Assumes nothing beyond a SystemVerilog compiler.
*/
package spa_pkg;

  typedef enum logic [1:0] {
    SPA_MODE_REG,
    SPA_MODE_CPLX,
    SPA_MODE_SIMPLE
  } spa_mode_t;

  typedef struct packed {
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [7:0]  paddr;
    logic [31:0] pwdata;
  } spa_apb_req_t;

  typedef struct packed {
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
  } spa_apb_rsp_t;

endpackage

// ---- testbench/configurable_sum_of_products_array_tb.sv ----
/*
  Self-checking bench for the sum-of-products array: APB programming, mode table
  and pin checks through a queue of expected results. Assumes spa_board beside it.
*/
`timescale 1ns/10ps
`include "spa_cfg.svh"

module configurable_sum_of_products_array_tb;
  import spa_pkg::*;
  typedef struct packed {
    logic        pin;
    logic [32:0] exp;
    logic [32:0] msk;
  } spa_note_t;

  logic         pclk;
  logic         presetn;
  spa_apb_req_t req;
  spa_apb_rsp_t rsp;
  logic [7:0]   din, f_in, f_out, f_oe, din_w;
  logic         dev_clk, oe_n, clk_w, oen_w, smp;
  spa_note_t    notes[$];
  spa_note_t    nt;
  int           fails, n_tests;
  integer       seed;
  logic [31:0]  v;
  logic [63:0]  sig;

  spa_array u_spa_array (.pclk(pclk), .presetn(presetn), .apb_req(req), .apb_rsp(rsp),
    .din(din), .dev_clk(dev_clk), .oe_n(oe_n), .f_in(f_in), .f_out(f_out), .f_oe(f_oe));
  spa_board u_spa_board (.pclk(pclk), .din_want(din_w), .clk_want(clk_w), .oen_want(oen_w),
    .f_out(f_out), .f_oe(f_oe), .din(din), .dev_clk(dev_clk), .oe_n(oe_n), .f_in(f_in));

  initial begin
    pclk = 1'b0;
    forever #12.5 pclk = ~pclk;
  end

  task automatic check(input string name, input logic [32:0] seen, input logic [32:0] exp);
    n_tests++;
    if (seen !== exp) begin
      fails++;
      $display("[ERR] %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", n_tests, fails);
    if (fails == 0 && n_tests > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  // Monitor: each read completion or pin sample takes the oldest note
  always @(posedge pclk) begin
    if (smp || (req.psel && req.penable && rsp.pready === 1'b1 && !req.pwrite)) begin
      nt = notes.pop_front();
      if (nt.pin)
        check("pins", {17'h0, f_oe, f_out} & nt.msk, nt.exp);
      else
        check("prdata", {rsp.pslverr, rsp.prdata} & nt.msk, nt.exp);
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    req <= '{1'b1, 1'b0, wr, a, d};
    @(posedge pclk);
    req.penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (rsp.pready !== 1'b1 && n < 20);
    if (n >= 20)
      fails++;
    req <= '0;
    @(posedge pclk);
  endtask

  task automatic rd(input logic [7:0] a, input logic [32:0] e, input logic [32:0] m);
    notes.push_back('{1'b0, e & m, m});
    apb(1'b0, a, 32'h0);
  endtask

  task automatic pins(input logic [15:0] e, input logic [15:0] m);
    notes.push_back('{1'b1, {17'h0, e & m}, {17'h0, m}});
    repeat (4) @(posedge pclk);
    smp <= 1'b1;
    @(posedge pclk);
    smp <= 1'b0;
  endtask

  task automatic prog(input logic [5:0] r, input logic [81:0] d);
    check("user row", {32'h0, r >= `SPA_ROW_RSV_LO && r <= `SPA_ROW_RSV_HI}, 33'h0);
    apb(1'b1, `SPA_OFF_ROW, {26'h0, r});
    apb(1'b1, `SPA_OFF_WD0, d[31:0]);
    apb(1'b1, `SPA_OFF_WD1, d[63:32]);
    apb(1'b1, `SPA_OFF_WD2, {14'h0, d[81:64]});
    apb(1'b1, `SPA_OFF_CMD, 32'h1);
  endtask

  task automatic rrow(input logic [5:0] r, input logic [63:0] e);
    apb(1'b1, `SPA_OFF_ROW, {26'h0, r});
    rd(`SPA_OFF_RD0, {1'b0, e[31:0]}, 33'h0ffffffff);
    rd(`SPA_OFF_RD1, {1'b0, e[63:32]}, 33'h0ffffffff);
  endtask

  task automatic dclk();
    clk_w <= 1'b1;
    repeat (3) @(posedge pclk);
    clk_w <= 1'b0;
    repeat (3) @(posedge pclk);
  endtask

  function automatic logic [81:0] acw(input logic sy, input logic am, input logic [7:0] c,
                                      input logic [7:0] pol);
    return {sy, am, c, pol, 64'hffff_ffff_ffff_ffff};
  endfunction

  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (20000) @(posedge pclk);
    fails++;
    report_and_stop();
  end

  initial begin
    presetn = 1'b0;
    req = '0;
    din_w = 8'h00;
    clk_w = 1'b0;
    oen_w = 1'b0;
    smp = 1'b0;
    fails = 0;
    n_tests = 0;
    seed = 32'heec8dba4;
    sig = 64'h0123_4567_89ab_cdef;
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    rd(`SPA_OFF_STATUS, 33'h20000, 33'h70000);
    pins(16'h0000, 16'hff00);
    prog(`SPA_ROW_ACW, acw(1'b0, 1'b1, 8'h00, 8'hff));
    rd(`SPA_OFF_STATUS, 33'h00000, 33'h60000);
    // Device clock inside the reset time must not disturb the cleared registers
    dclk();
    pins(16'hffff, 16'hffff);
    repeat (400) @(posedge pclk);
    rd(`SPA_OFF_STATUS, 33'h80000, 33'h80000);
    dclk();
    pins(16'hff00, 16'hffff);
    // Term 0 becomes din[0]; every other term keeps both polarities of din[0]
    for (int r = 0; r < 32; r++)
      prog(r[5:0], {18'h0, 63'h7fff_ffff_ffff_ffff, r == 0});
    din_w <= 8'h01;
    dclk();
    pins(16'hff01, 16'hffff);
    din_w <= 8'h00;
    pins(16'hff01, 16'hffff);
    oen_w <= 1'b1;
    pins(16'h0000, 16'hff00);
    oen_w <= 1'b0;
    for (int m = 0; m < 3; m++) begin
      case (m)
        0:       prog(`SPA_ROW_ACW, acw(1'b0, 1'b1, 8'h01, 8'hff));
        1:       prog(`SPA_ROW_ACW, acw(1'b1, 1'b1, 8'hff, 8'hff));
        default: prog(`SPA_ROW_ACW, acw(1'b1, 1'b0, 8'h80, 8'hfe));
      endcase
      for (int i = 0; i < 3; i++) begin
        v = $random(seed);
        din_w <= v[7:0];
        case (m)
          0:       pins({7'h7f, v[0], 8'h00}, 16'hffff);
          1:       pins({7'h00, v[0], 8'h00}, 16'hff01);
          default: pins({8'h7f, 7'h00, ~v[0]}, 16'hff01);
        endcase
      end
    end
    prog(`SPA_ROW_SIG, {18'h0, sig});
    rrow(`SPA_ROW_SIG, sig);
    rrow(6'd0, 64'hffff_ffff_ffff_ffff);
    prog(`SPA_ROW_SEC, 82'h1);
    rrow(6'd0, 64'h0);
    rrow(`SPA_ROW_SIG, sig);
    rd(`SPA_OFF_STATUS, 33'h10000, 33'h10000);
    // Unmapped address answers with an error and zero data
    rd(8'h40, 33'h100000000, 33'h1ffffffff);
    prog(`SPA_ROW_ERASE, 82'h0);
    rrow(`SPA_ROW_SIG, 64'hffff_ffff_ffff_ffff);
    rrow(6'd1, 64'hffff_ffff_ffff_ffff);
    apb(1'b1, `SPA_OFF_ROW, {26'h0, `SPA_ROW_ACW});
    rd(`SPA_OFF_RD2, 33'h3ffff, 33'h3ffff);
    rd(`SPA_OFF_STATUS, 33'h20000, 33'h70000);
    report_and_stop();
  end
endmodule

// ---- testbench/spa_board.sv ----
/*
  Board model around the array: drives the dedicated inputs, the device clock pin
  and the common enable. Assumes the bench sets the wanted levels after pclk edges.
*/
`timescale 1ns/10ps

module spa_board (
  input  wire logic       pclk,
  input  wire logic [7:0] din_want,
  input  wire logic       clk_want,
  input  wire logic       oen_want,
  input  wire logic [7:0] f_out,
  input  wire logic [7:0] f_oe,
  output      logic [7:0] din,
  output      logic       dev_clk,
  output      logic       oe_n,
  output      logic [7:0] f_in
);
  logic [7:0] float_q;

  initial begin
    din = 8'h00;
    dev_clk = 1'b0;
    oe_n = 1'b1;
    float_q = 8'h5a;
  end

  always @(posedge pclk) begin
    din <= din_want;
    dev_clk <= clk_want;
    oe_n <= oen_want;
    float_q <= ~float_q;
  end

  // Released pins toggle so a stale level never passes for a driven one
  assign f_in = (f_oe & f_out) | (~f_oe & float_q);
endmodule
